// *** core/tfc_pkg.sv ***
// shared constants for the transmit framing and timing control block
package tfc_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_FRAMING   = 12'h005;
   localparam logic [11:0] IDX_TIMING    = 12'h006;
   localparam logic [11:0] IDX_IRQ_FIRST = 12'h007;
   localparam logic [11:0] IDX_IRQ_SEC   = 12'h008;
   localparam logic [11:0] IDX_IRQ_THIRD = 12'h009;
   localparam logic [11:0] IDX_DIAG      = 12'h00A;
   localparam int          ADDR_SHIFT    = 2;

   // framing and bypass options fields
   localparam int BIT_EBIT_ZERO  = 4;
   localparam int BIT_FRAME_DIS  = 3;
   localparam int BIT_SYNC_PASS  = 2;
   localparam int BIT_CRC_PASS   = 1;
   localparam int BIT_DL_PASS    = 0;
   localparam logic [7:0] FRAMING_RESET = 8'h00;
   localparam logic [7:0] FRAMING_MASK  = 8'h1F;

   // timing options fields
   localparam int OCLK_HI        = 5;
   localparam int OCLK_LO        = 4;
   localparam int PLL_REF_SEL_HI      = 3;
   localparam int PLL_REF_SEL_LO      = 2;
   localparam int BIT_STORE_BYP  = 0;
   localparam logic [7:0] TIMING_RESET = 8'h01;
   localparam logic [7:0] TIMING_MASK  = 8'h3D;

   // clock select encodings
   localparam logic [1:0] OCLK_ATTEN   = 2'h0;
   localparam logic [1:0] OCLK_AUX     = 2'h1;
   localparam logic [1:0] PLL_FIFO_IN  = 2'h0;
   localparam logic [1:0] PLL_BP       = 2'h1;
   localparam logic [1:0] PLL_RECOV    = 2'h2;
   localparam logic [1:0] PLL_AUX      = 2'h3;

   // diagnostics and loopback fields
   localparam int BIT_REVISION   = 6;
   localparam int BIT_PAYLOAD_LB = 5;
   localparam int BIT_LINE_LB    = 4;
   localparam int BIT_RAIS       = 3;
   localparam int BIT_DIAG_LB    = 2;
   localparam int BIT_MIMIC      = 1;
   localparam int BIT_TX_LOS     = 0;
   localparam logic [7:0] DIAG_RESET = 8'h00;
   localparam logic [7:0] DIAG_MASK  = 8'h3F;

   // synchronised clock vector positions
   localparam int CK_BP    = 0;
   localparam int CK_AUX   = 1;
   localparam int CK_RECOV = 2;
   localparam int CK_ATTEN = 3;
   localparam int NUM_CK   = 4;
endpackage : tfc_pkg

// *** core/tfc_tx_ctrl.sv ***
// transmit framing, timing select and interrupt source registers behind apb
// How it works
// - E1 out of multiframe: E-bits sent as ones if option 0, zeroes if 1
// - framing disable passes transmit data unchanged; otherwise framing inserted
// - sync passthrough reinserts backplane sync bit; otherwise framer makes it
// - T1 CRC-6 passthrough passes backplane CRC bits; otherwise framer computes them
// - T1 data link passthrough passes backplane link bits; otherwise framer makes them
// - store bypass, reset one, routes store inputs straight to outputs
// - output select 00 clocks FIFO output from the attenuated clock
// - output select 01 uses the aux clock; software sets PLL ref 11
// - upper select bit uses FIFO input clock, no attenuation; PLL ref 00
// - PLL ref 00 FIFO input, 01 backplane, 10 recovered, 11 aux clock
// - reset clears clock select and PLL reference fields
// - line loopback with attenuation ignores backplane transmit data
// - upper select with backplane input: line clock equals backplane clock
// - select 01 with reference 11: line clock equals aux clock
// - three read-only source registers, one bit per internal block
// - reading source registers never clears; only block status reads do
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tfc_tx_ctrl #(
   parameter logic REVISION_VALUE = 1'b0   // arbitrary value
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [13:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // mode and framer status
   input  wire logic        e1_mode_i,
   input  wire logic        mf_aligned_i,
   input  wire logic        backplane_clk_dir_i,
   // frame position marks from the basic transmit framer
   input  wire logic        pos_sync_i,
   input  wire logic        pos_crc_i,
   input  wire logic        pos_datalink_i,
   input  wire logic        pos_ebit_i,
   input  wire logic        framer_bit_i,
   // data sources
   input  wire logic        backplane_tx_stream_i,
   input  wire logic        store_out_data_i,
   input  wire logic        rx_recovered_data_i,
   // clocks from outside this domain
   input  wire logic        backplane_tx_clock_i,
   input  wire logic        aux_tx_clock_in_i,
   input  wire logic        rx_recovered_clock_i,
   input  wire logic        atten_clock_i,
   // interrupt lines of the internal blocks
   input  wire logic [23:0] block_irq_i,
   // outputs
   output logic             tx_line_data_o,
   output logic             tx_line_clock_out_o,
   output logic             fifo_out_clock_o,
   output logic             pll_ref_clock_o,
   output logic             jitter_atten_on_o,
   output logic             tx_store_bypass_o,
   output logic             payload_loopback_o,
   output logic             line_loopback_o,
   output logic             rx_force_ais_o,
   output logic             diag_digital_loopback_o,
   output logic             mimic_framing_o,
   output logic             tx_suppress_o,
   output logic             irq_out_n_o
);

   logic [7:0]  framing_q;
   logic [7:0]  timing_q;
   logic [7:0]  diag_q;
   logic [7:0]  irq_src_q [3];
   logic [tfc_pkg::NUM_CK-1:0] ck_meta_q;
   logic [tfc_pkg::NUM_CK-1:0] ck_sync_q;
   logic [11:0] reg_idx;
   logic        wr_en;
   logic        rd_en;
   logic        hit;
   logic [7:0]  rd_val;
   logic [1:0]  oclk_sel;
   logic [1:0]  pll_sel;
   logic        line_lb;
   logic        fifo_in_clk;
   logic        fifo_out_d;
   logic        pll_ref_d;
   logic        store_data;
   logic        src_bit;
   logic        data_d;

   // register index from a byte address
   function automatic logic [11:0] word_index(input logic [13:0] addr);
      word_index = addr[13:tfc_pkg::ADDR_SHIFT];
   endfunction : word_index

   // true when the index names a mapped register
   function automatic logic is_mapped(input logic [11:0] idx);
      is_mapped = (idx >= tfc_pkg::IDX_FRAMING) && (idx <= tfc_pkg::IDX_DIAG);
   endfunction : is_mapped

   // bus decode; slave answers in the first access cycle
   assign reg_idx   = word_index(paddr_i);
   assign hit       = is_mapped(reg_idx) && (paddr_i[1:0] == 2'h0);
   assign wr_en     = psel_i && penable_i && pwrite_i && hit;
   assign rd_en     = psel_i && penable_i && !pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;

   // framing and bypass options register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         framing_q <= tfc_pkg::FRAMING_RESET;
      end else if (wr_en && reg_idx == tfc_pkg::IDX_FRAMING) begin
         framing_q <= pwdata_i[7:0] & tfc_pkg::FRAMING_MASK;
      end
   end

   // timing options register, store bypass set at reset
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         timing_q <= tfc_pkg::TIMING_RESET;
      end else if (wr_en && reg_idx == tfc_pkg::IDX_TIMING) begin
         timing_q <= pwdata_i[7:0] & tfc_pkg::TIMING_MASK;
      end
   end

   // diagnostics and loopback register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         diag_q <= tfc_pkg::DIAG_RESET;
      end else if (wr_en && reg_idx == tfc_pkg::IDX_DIAG) begin
         diag_q <= pwdata_i[7:0] & tfc_pkg::DIAG_MASK;
      end
   end

   // interrupt sources follow the blocks; bus reads never touch them
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_src_q[0] <= 8'h00;
         irq_src_q[1] <= 8'h00;
         irq_src_q[2] <= 8'h00;
      end else begin
         irq_src_q[0] <= block_irq_i[7:0];
         irq_src_q[1] <= block_irq_i[15:8];
         irq_src_q[2] <= block_irq_i[23:16];
      end
   end

   // read multiplexer
   always_comb begin
      rd_val = 8'h00;
      case (reg_idx)
         tfc_pkg::IDX_FRAMING:   rd_val = framing_q;
         tfc_pkg::IDX_TIMING:    rd_val = timing_q;
         tfc_pkg::IDX_IRQ_FIRST: rd_val = irq_src_q[0];
         tfc_pkg::IDX_IRQ_SEC:   rd_val = irq_src_q[1];
         tfc_pkg::IDX_IRQ_THIRD: rd_val = irq_src_q[2];
         tfc_pkg::IDX_DIAG: begin
            rd_val = diag_q;
            rd_val[tfc_pkg::BIT_REVISION] = REVISION_VALUE;
         end
         default:                rd_val = 8'h00;
      endcase
   end

   // read data registered in the setup cycle, ready for the access cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= {24'h00_0000, hit ? rd_val : 8'h00};
      end
   end

   // two-stage synchronisers for the outside clocks
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ck_meta_q <= '0;
         ck_sync_q <= '0;
      end else begin
         ck_meta_q <= {atten_clock_i, rx_recovered_clock_i, aux_tx_clock_in_i, backplane_tx_clock_i};
         ck_sync_q <= ck_meta_q;
      end
   end

   // clock selection
   assign oclk_sel    = timing_q[tfc_pkg::OCLK_HI:tfc_pkg::OCLK_LO];
   assign pll_sel     = timing_q[tfc_pkg::PLL_REF_SEL_HI:tfc_pkg::PLL_REF_SEL_LO];
   assign line_lb     = diag_q[tfc_pkg::BIT_LINE_LB];
   assign fifo_in_clk = line_lb ? ck_sync_q[tfc_pkg::CK_RECOV] : ck_sync_q[tfc_pkg::CK_BP];

   // fifo output clock source
   always_comb begin
      fifo_out_d = ck_sync_q[tfc_pkg::CK_ATTEN];
      if (oclk_sel[1]) begin
         fifo_out_d = fifo_in_clk;
      end else if (oclk_sel == tfc_pkg::OCLK_AUX) begin
         fifo_out_d = ck_sync_q[tfc_pkg::CK_AUX];
      end else begin
         fifo_out_d = ck_sync_q[tfc_pkg::CK_ATTEN];
      end
   end

   // pll reference source
   always_comb begin
      pll_ref_d = fifo_in_clk;
      case (pll_sel)
         tfc_pkg::PLL_FIFO_IN: pll_ref_d = fifo_in_clk;
         tfc_pkg::PLL_BP:      pll_ref_d = ck_sync_q[tfc_pkg::CK_BP];
         tfc_pkg::PLL_RECOV:   pll_ref_d = ck_sync_q[tfc_pkg::CK_RECOV];
         tfc_pkg::PLL_AUX:     pll_ref_d = ck_sync_q[tfc_pkg::CK_AUX];
         default:              pll_ref_d = fifo_in_clk;
      endcase
   end

   // registered clock outputs
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fifo_out_clock_o    <= 1'b0;
         tx_line_clock_out_o <= 1'b0;
         pll_ref_clock_o     <= 1'b0;
         jitter_atten_on_o   <= 1'b1;
      end else begin
         fifo_out_clock_o    <= fifo_out_d;
         tx_line_clock_out_o <= fifo_out_d;
         pll_ref_clock_o     <= pll_ref_d;
         jitter_atten_on_o   <= (oclk_sel == tfc_pkg::OCLK_ATTEN);
      end
   end

   // data source: loopback data replaces backplane data
   assign store_data = timing_q[tfc_pkg::BIT_STORE_BYP] ? backplane_tx_stream_i : store_out_data_i;
   assign src_bit    = line_lb ? rx_recovered_data_i : store_data;

   // framing insertion per bit position
   always_comb begin
      data_d = src_bit;
      if (framing_q[tfc_pkg::BIT_FRAME_DIS]) begin
         data_d = src_bit;
      end else if (pos_sync_i) begin
         data_d = framing_q[tfc_pkg::BIT_SYNC_PASS] ? src_bit : framer_bit_i;
      end else if (pos_crc_i && !e1_mode_i) begin
         data_d = framing_q[tfc_pkg::BIT_CRC_PASS] ? src_bit : framer_bit_i;
      end else if (pos_datalink_i && !e1_mode_i) begin
         data_d = framing_q[tfc_pkg::BIT_DL_PASS] ? src_bit : framer_bit_i;
      end else if (pos_ebit_i && e1_mode_i && !mf_aligned_i) begin
         data_d = !framing_q[tfc_pkg::BIT_EBIT_ZERO];
      end else if (pos_crc_i || pos_datalink_i || pos_ebit_i) begin
         data_d = framer_bit_i;
      end else begin
         data_d = src_bit;
      end
   end

   // registered line data
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_line_data_o <= 1'b0;
      end else begin
         tx_line_data_o <= data_d;
      end
   end

   // interrupt output follows the source registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_out_n_o <= 1'b1;
      end else begin
         irq_out_n_o <= ~(|{irq_src_q[0], irq_src_q[1], irq_src_q[2]});
      end
   end

   // control levels straight from the registers
   assign tx_store_bypass_o       = timing_q[tfc_pkg::BIT_STORE_BYP];
   assign payload_loopback_o      = diag_q[tfc_pkg::BIT_PAYLOAD_LB];
   assign line_loopback_o         = diag_q[tfc_pkg::BIT_LINE_LB];
   assign rx_force_ais_o          = diag_q[tfc_pkg::BIT_RAIS];
   assign diag_digital_loopback_o = diag_q[tfc_pkg::BIT_DIAG_LB];
   assign mimic_framing_o         = diag_q[tfc_pkg::BIT_MIMIC];
   assign tx_suppress_o           = diag_q[tfc_pkg::BIT_TX_LOS];

   // e-bit value while out of multiframe
   ebit_value_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (e1_mode_i && !mf_aligned_i && pos_ebit_i && !pos_sync_i && !framing_q[tfc_pkg::BIT_FRAME_DIS])
      |=> tx_line_data_o == !$past(framing_q[tfc_pkg::BIT_EBIT_ZERO]))
      else $error("e-bit value wrong while out of multiframe");

   // framing disable passes data
   frame_dis_pass_a: assert property (@(posedge clk_i) disable iff (srst_i)
      framing_q[tfc_pkg::BIT_FRAME_DIS] && !line_lb && timing_q[tfc_pkg::BIT_STORE_BYP]
      |=> tx_line_data_o == $past(backplane_tx_stream_i))
      else $error("framing disable did not pass data");

   // sync bit generated by framer when not passed
   sync_gen_a: assert property (@(posedge clk_i) disable iff (srst_i)
      pos_sync_i && !framing_q[tfc_pkg::BIT_FRAME_DIS] && !framing_q[tfc_pkg::BIT_SYNC_PASS]
      |=> tx_line_data_o == $past(framer_bit_i))
      else $error("sync bit not from framer");

   // aux clock reaches the line clock output
   aux_line_clk_a: assert property (@(posedge clk_i) disable iff (srst_i)
      oclk_sel == tfc_pkg::OCLK_AUX ##1 oclk_sel == tfc_pkg::OCLK_AUX
      |-> tx_line_clock_out_o == $past(ck_sync_q[tfc_pkg::CK_AUX]))
      else $error("line clock not following aux clock");

   // backplane clock reaches the line clock output
   bp_line_clk_a: assert property (@(posedge clk_i) disable iff (srst_i)
      oclk_sel[1] && !line_lb && backplane_clk_dir_i
      |=> tx_line_clock_out_o == $past(ck_sync_q[tfc_pkg::CK_BP]) && !jitter_atten_on_o)
      else $error("line clock not following backplane clock");

   // recovered clock as pll reference
   pll_recov_a: assert property (@(posedge clk_i) disable iff (srst_i)
      pll_sel == tfc_pkg::PLL_RECOV |=> pll_ref_clock_o == $past(ck_sync_q[tfc_pkg::CK_RECOV]))
      else $error("pll reference not recovered clock");

   // reset values of the timing register
   timing_reset_a: assert property (@(posedge clk_i)
      srst_i |=> timing_q == tfc_pkg::TIMING_RESET && tx_store_bypass_o)
      else $error("timing register reset value wrong");

   // interrupt output tracks sources two cycles later
   irq_assert_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (|block_irq_i) |=> ##1 !irq_out_n_o)
      else $error("interrupt output not asserted");

   // source register reads leave the indication
   irq_noclear_a: assert property (@(posedge clk_i) disable iff (srst_i)
      rd_en && reg_idx == tfc_pkg::IDX_IRQ_FIRST && block_irq_i[7:0] != 8'h00 && $stable(block_irq_i)
      ##1 $stable(block_irq_i)
      |-> irq_src_q[0] == $past(block_irq_i[7:0]) && !irq_out_n_o)
      else $error("source read cleared an indication");

endmodule : tfc_tx_ctrl
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the transmit framing and timing control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [13:0] A_FR = {tfc_pkg::IDX_FRAMING, 2'b00};
   localparam logic [13:0] A_TM = {tfc_pkg::IDX_TIMING, 2'b00};
   localparam logic [13:0] A_DG = {tfc_pkg::IDX_DIAG, 2'b00};
   logic        clk_i = 1'b0, srst_i = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0, prdata_o;
   logic        pready_o, pslverr_o;
   logic        e1_mode = 1'b0, mf_al = 1'b0, pos_sync = 1'b0, pos_crc = 1'b0, pos_dl = 1'b0, pos_eb = 1'b0;
   logic        framer_bit = 1'b0, bp_data = 1'b0, st_data = 1'b0, rx_data = 1'b0;
   logic [23:0] block_irq = 24'h0;
   logic        ck_bp, ck_aux, ck_rec, ck_att;
   logic        tx_line_data_o, tx_line_clock_out_o, fifo_out_clock_o, pll_ref_clock_o, jitter_atten_on_o;
   logic        tx_store_bypass_o, irq_out_n_o;
   logic [5:0]  diag_o;
   logic [5:0][3:0] h = '0;
   int          err_count = 0, cmp_count = 0, fidx, pidx, lidx, k, i;
   bit          mon_on = 1'b0;
   logic [31:0] q;
   logic        e;
   int          cf [6] = '{8'h01, 8'h1D, 8'h21, 8'h05, 8'h09, 8'h31};
   int          cfi [6] = '{3, 1, 0, 3, 3, 0};
   int          cpi [6] = '{0, 1, 0, 0, 2, 0};
   int          cli [6] = '{-1, 1, 0, -1, -1, 0};
   // 40 MHz system clock
   always #12.5 clk_i = ~clk_i;
   tfc_far_model fm (.bp_clk_o(ck_bp), .aux_clk_o(ck_aux), .recov_clk_o(ck_rec), .atten_clk_o(ck_att));
   tfc_tx_ctrl dut (
      .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .e1_mode_i(e1_mode), .mf_aligned_i(mf_al), .backplane_clk_dir_i(1'b1),
      .pos_sync_i(pos_sync), .pos_crc_i(pos_crc), .pos_datalink_i(pos_dl), .pos_ebit_i(pos_eb),
      .framer_bit_i(framer_bit), .backplane_tx_stream_i(bp_data), .store_out_data_i(st_data),
      .rx_recovered_data_i(rx_data), .backplane_tx_clock_i(ck_bp), .aux_tx_clock_in_i(ck_aux),
      .rx_recovered_clock_i(ck_rec), .atten_clock_i(ck_att), .block_irq_i(block_irq),
      .tx_line_data_o(tx_line_data_o), .tx_line_clock_out_o(tx_line_clock_out_o),
      .fifo_out_clock_o(fifo_out_clock_o), .pll_ref_clock_o(pll_ref_clock_o),
      .jitter_atten_on_o(jitter_atten_on_o), .tx_store_bypass_o(tx_store_bypass_o),
      .payload_loopback_o(diag_o[5]), .line_loopback_o(diag_o[4]), .rx_force_ais_o(diag_o[3]),
      .diag_digital_loopback_o(diag_o[2]), .mimic_framing_o(diag_o[1]), .tx_suppress_o(diag_o[0]),
      .irq_out_n_o(irq_out_n_o));
   // verdict and end of run
   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // compare seen against expected
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // one apb transfer: setup, then access until pready
   task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         end_sim();
      end
      q = prdata_o;
      e = pslverr_o;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [13:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   // read and compare data, error flag clear
   task rd_chk(input string nm, input logic [13:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(nm, q, x);
      check("pslverr", {31'h0, e}, 32'h0);
   endtask : rd_chk
   // program framing options, present one bit, compare line data
   task dbit(input logic [7:0] fc, input logic [5:0] m, input logic [3:0] s, input logic x);
      wr(A_FR, {24'h0, fc});
      {e1_mode, mf_al, pos_sync, pos_crc, pos_dl, pos_eb} <= m;
      {framer_bit, bp_data, st_data, rx_data} <= s;
      repeat (3) @(posedge clk_i);
      check("line_data", {31'h0, tx_line_data_o}, {31'h0, x});
   endtask : dbit
   // clock source history; outputs show the pin as sampled 2.5 cycles back,
   // between h[2] and h[1], so compare only where the source sat still there
   always @(negedge clk_i) begin
      h <= {h[4:0], ck_att, ck_rec, ck_aux, ck_bp};
      if (mon_on && h[1][fidx] == h[2][fidx] && h[3][fidx] == h[2][fidx]) begin
         check("fifo_clk", {31'h0, fifo_out_clock_o}, {31'h0, h[2][fidx]});
      end
      if (mon_on && h[1][pidx] == h[2][pidx] && h[3][pidx] == h[2][pidx]) begin
         check("pll_clk", {31'h0, pll_ref_clock_o}, {31'h0, h[2][pidx]});
      end
      if (mon_on && lidx >= 0 && h[1][lidx] == h[2][lidx] && h[3][lidx] == h[2][lidx]) begin
         check("line_clk", {31'h0, tx_line_clock_out_o}, {31'h0, h[2][lidx]});
      end
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      srst_i <= 1'b0;
      rd_chk("framing", A_FR, 32'h0);
      rd_chk("timing", A_TM, 32'h1);
      check("store_byp", {31'h0, tx_store_bypass_o}, 32'h1);
      rd_chk("diag", A_DG, 32'h0);
      apb(1'b0, 14'h0, 32'h0);
      check("unmapped", {31'h0, e}, 32'h1);
      apb(1'b0, A_TM + 14'h1, 32'h0);
      check("misaligned", {31'h0, e}, 32'h1);
      wr(A_TM, 32'hFF);
      rd_chk("timing_mask", A_TM, 32'h3D);
      $display("registers done");
      for (k = 0; k < 6; k++) begin
         wr(A_TM, cf[k]);
         fidx = cfi[k];
         pidx = cpi[k];
         lidx = cli[k];
         repeat (8) @(posedge clk_i);
         mon_on = 1'b1;
         repeat (80) @(posedge clk_i);
         mon_on = 1'b0;
         check("atten_on", {31'h0, jitter_atten_on_o}, {31'h0, cf[k][5:4] == 2'h0});
      end
      $display("clock select done");
      dbit(8'h00, 6'b001000, 4'b1000, 1'b1);
      dbit(8'h04, 6'b001000, 4'b0100, 1'b1);
      dbit(8'h08, 6'b001000, 4'b0100, 1'b1);
      dbit(8'h02, 6'b000100, 4'b0100, 1'b1);
      dbit(8'h00, 6'b000100, 4'b1000, 1'b1);
      dbit(8'h01, 6'b000010, 4'b0100, 1'b1);
      dbit(8'h00, 6'b000010, 4'b1000, 1'b1);
      dbit(8'h00, 6'b100001, 4'b0000, 1'b1);
      dbit(8'h10, 6'b100001, 4'b1000, 1'b0);
      dbit(8'h10, 6'b110001, 4'b1000, 1'b1);
      dbit(8'h00, 6'b000000, 4'b0100, 1'b1);
      wr(A_TM, 32'h0);
      @(posedge clk_i);
      check("store_byp", {31'h0, tx_store_bypass_o}, 32'h0);
      dbit(8'h00, 6'b000000, 4'b0010, 1'b1);
      wr(A_DG, 32'h10);
      dbit(8'h00, 6'b000000, 4'b0101, 1'b1);
      for (i = 0; i < 6; i++) begin
         wr(A_DG, 32'h1 << i);
         repeat (2) @(posedge clk_i);
         check("diag_outs", {26'h0, diag_o}, 32'h1 << i);
      end
      rd_chk("diag_rb", A_DG, 32'h20);
      wr(A_DG, 32'h0);
      $display("data path done");
      for (k = 0; k < 3; k++) begin
         block_irq <= 24'h8 << (8 * k);
         repeat (4) @(posedge clk_i);
         rd_chk("irq_src", A_FR + 14'h8 + 14'h4 * k[13:0], 32'h8);
         wr(A_FR + 14'h8 + 14'h4 * k[13:0], 32'h0);
         rd_chk("irq_keep", A_FR + 14'h8 + 14'h4 * k[13:0], 32'h8);
         check("irq_n_low", {31'h0, irq_out_n_o}, 32'h0);
         block_irq <= 24'h0;
         repeat (4) @(posedge clk_i);
         check("irq_n_high", {31'h0, irq_out_n_o}, 32'h1);
         rd_chk("irq_clr", A_FR + 14'h8 + 14'h4 * k[13:0], 32'h0);
      end
      $display("interrupt sources done");
      end_sim();
   end
endmodule : testbench
`default_nettype wire

// *** verification/tfc_far_model.sv ***
// far side clock sources: backplane, aux, recovered and attenuated clocks
`timescale 1ns/1ps
`default_nettype none
module tfc_far_model (
   output logic bp_clk_o,
   output logic aux_clk_o,
   output logic recov_clk_o,
   output logic atten_clk_o
);
   // idle levels at time zero
   initial begin
      bp_clk_o    = 1'b0;
      aux_clk_o   = 1'b0;
      recov_clk_o = 1'b0;
      atten_clk_o = 1'b0;
   end
   // free running clocks, periods unrelated so each source is told apart
   always #100 bp_clk_o = ~bp_clk_o;
   always #140 aux_clk_o = ~aux_clk_o;
   always #180 recov_clk_o = ~recov_clk_o;
   always #220 atten_clk_o = ~atten_clk_o;
endmodule : tfc_far_model
`default_nettype wire
